// [logic/ifs_frame_slave.sv]
// Slave end of the inter-chip serial link: framing, checks, dispatch, reply.
//
// Summary of operation
// - One master, one slave, point to point.
// - Slave only answers master command frames.
// - Config word three bits [2:0], any one set, enable link.
// - Rates 6.1 Kbps to 6 Mbps, 1 Mbps default.
// - Rate changeable at start-up or running.
// - Over three framing errors restore default rate.
// - Flag, seq, reserved, object, data, CRC, flag.
// - Sequence advances per frame, receiver checks it.
// - Wrong sequence: drop frame, no reply.
// - CRC covers object number and data bytes.
// - Bad CRC: drop frame silently, no reply.
// - Each good command gets exactly one reply.
// - Dispatch objects 0, 1, 6, 7; others reserved.
// - Object 0 uses data byte 0 only.
// - Inquiry 0: motor, PFC state, then 0xFF bytes.
// - Inquiry 1: execution time and processor load.
// - Parse once a whole frame is received.
// - Build reply and queue it for sending.
// - Inquiry 1 words are sent low byte first.
// - Object 1 echoes command and value words.
// - Rate change: object 1, command 0x0100, rate/100.
`include "ifs_cfg.svh"

module ifs_frame_slave
  import ifs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [2:0]  link_cfg_in,
  input  wire logic        rx_in,
  input  wire logic [7:0]  motor_state_in,
  input  wire logic [7:0]  pfc_state_in,
  input  wire logic [15:0] exec_time_in,
  input  wire logic [15:0] cpu_load_in,
  input  wire logic [15:0] param_rdata_in,
  output logic             tx_out,
  output logic [15:0]      baud_value_out,
  output logic             syscfg_stb_out,
  output ifs_syscfg_t      syscfg_out,
  output logic             param_rd_stb_out,
  output logic             param_wr_stb_out,
  output ifs_param_t       param_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `IFS_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_step

  // The CRC runs over the object number (low nibble) and the data bytes.
  function automatic logic [7:0] frame_crc(input logic [3:0]      mo,
                                           input logic [3:0][7:0] data);
    logic [7:0] c;
    c = crc8_step(`IFS_CRC_INIT, {4'h0, mo});
    for (int i = 0; i < 4; i++) begin
      c = crc8_step(c, data[i]);
    end
    return c;
  endfunction : frame_crc

  function automatic logic [7:0] reply_byte(input logic [2:0] idx,
                                            input ifs_frame_t f,
                                            input logic [7:0] crc);
    logic [7:0] b;
    b = `IFS_FLAG;
    unique case (idx)
      3'h0: b = `IFS_FLAG;
      3'h1: b = {f.seq, f.res, f.mo};
      3'h2: b = f.data[0];
      3'h3: b = f.data[1];
      3'h4: b = f.data[2];
      3'h5: b = f.data[3];
      3'h6: b = crc;
      3'h7: b = `IFS_FLAG;
    endcase
    return b;
  endfunction : reply_byte

  // ----------------------------------------------------------------
  // Link enable and bit rate ticks
  // ----------------------------------------------------------------
  logic        link_en;
  logic [15:0] baud_ff;
  logic [26:0] acc_ff;
  logic [26:0] nxt_acc;
  logic        tick;
  logic [2:0]  err_cnt_ff;
  logic        ferr_stb;
  logic        tx_done;
  logic [15:0] pend_baud_ff;
  logic        pend_ff;

  assign link_en = |link_cfg_in;

  // Fractional accumulator: four ticks per bit at baud_ff * 100 bit/s.
  assign nxt_acc = acc_ff + {1'b0, 26'(baud_ff * `IFS_RATE_MUL)};
  assign tick    = link_en && (nxt_acc >= `IFS_CLK_HZ);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_ff <= 27'h0;
    end else if (!link_en) begin
      acc_ff <= 27'h0;
    end else if (tick) begin
      acc_ff <= nxt_acc - `IFS_CLK_HZ;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      baud_ff    <= `IFS_BAUD_DEF;
      err_cnt_ff <= 3'h0;
    end else if (ferr_stb && err_cnt_ff == `IFS_ERR_LIMIT) begin
      baud_ff    <= `IFS_BAUD_DEF;
      err_cnt_ff <= 3'h0;
    end else if (tx_done && pend_ff) begin
      baud_ff    <= pend_baud_ff;
      err_cnt_ff <= 3'h0;
    end else if (ferr_stb) begin
      err_cnt_ff <= err_cnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Byte receiver
  // ----------------------------------------------------------------
  ifs_rx_st_t rx_st_ff;
  logic [1:0] rx_ph_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic       byte_stb_ff;
  logic       ferr_ff;
  logic       rx_prev_ff;

  assign ferr_stb = ferr_ff;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_st_ff    <= IFS_R_IDLE;
      rx_ph_ff    <= 2'h0;
      rx_bit_ff   <= 3'h0;
      rx_sh_ff    <= 8'h00;
      byte_stb_ff <= 1'b0;
      ferr_ff     <= 1'b0;
      rx_prev_ff  <= 1'b1;
    end else begin
      byte_stb_ff <= 1'b0;
      ferr_ff     <= 1'b0;
      rx_prev_ff  <= rx_in;
      if (!link_en) begin
        rx_st_ff <= IFS_R_IDLE;
        rx_ph_ff <= 2'h0;
      end else begin
        unique case (rx_st_ff)
          IFS_R_IDLE: begin
            // A start needs a falling edge, so a low stop bit is no start.
            if (rx_prev_ff && !rx_in) begin
              rx_st_ff <= IFS_R_START;
              rx_ph_ff <= 2'h0;
            end
          end
          IFS_R_START: begin
            if (tick) begin
              if (rx_ph_ff == 2'h1) begin
                rx_st_ff  <= rx_in ? IFS_R_IDLE : IFS_R_DATA;
                rx_ph_ff  <= 2'h0;
                rx_bit_ff <= 3'h0;
              end else begin
                rx_ph_ff <= rx_ph_ff + 2'h1;
              end
            end
          end
          IFS_R_DATA: begin
            if (tick) begin
              rx_ph_ff <= rx_ph_ff + 2'h1;
              if (rx_ph_ff == 2'h3) begin
                rx_sh_ff  <= {rx_in, rx_sh_ff[7:1]};
                rx_bit_ff <= rx_bit_ff + 3'h1;
                if (rx_bit_ff == 3'h7) begin
                  rx_st_ff <= IFS_R_STOP;
                end
              end
            end
          end
          IFS_R_STOP: begin
            if (tick) begin
              rx_ph_ff <= rx_ph_ff + 2'h1;
              if (rx_ph_ff == 2'h3) begin
                byte_stb_ff <= rx_in;
                ferr_ff     <= !rx_in;
                rx_st_ff    <= IFS_R_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  logic [3:0] fr_cnt_ff;
  logic [7:0] fr_buf_ff [0:5];
  logic       frame_rdy_ff;
  ifs_frame_t rx_frame;
  logic       crc_ok;

  assign rx_frame = {fr_buf_ff[0], fr_buf_ff[4], fr_buf_ff[3],
                     fr_buf_ff[2], fr_buf_ff[1]};
  assign crc_ok   = frame_crc(rx_frame.mo, rx_frame.data) == fr_buf_ff[5];

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fr_cnt_ff    <= 4'h0;
      frame_rdy_ff <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        fr_buf_ff[i] <= 8'h00;
      end
    end else begin
      frame_rdy_ff <= 1'b0;
      if (!link_en) begin
        fr_cnt_ff <= 4'h0;
      end else if (byte_stb_ff) begin
        if (fr_cnt_ff == 4'h0) begin
          if (rx_sh_ff == `IFS_FLAG) begin
            fr_cnt_ff <= 4'h1;
          end
        end else if (fr_cnt_ff == 4'h7) begin
          // A closing flag may also open the next frame.
          frame_rdy_ff <= (rx_sh_ff == `IFS_FLAG);
          fr_cnt_ff    <= (rx_sh_ff == `IFS_FLAG) ? 4'h1 : 4'h0;
        end else if (fr_cnt_ff == 4'h1 && rx_sh_ff == `IFS_FLAG) begin
          fr_cnt_ff <= 4'h1;
        end else begin
          fr_buf_ff[3'(fr_cnt_ff - 4'h1)] <= rx_sh_ff;
          fr_cnt_ff <= fr_cnt_ff + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command check and dispatch
  // ----------------------------------------------------------------
  ifs_proc_st_t p_st_ff;
  ifs_frame_t   resp_ff;
  logic [1:0]   exp_seq_ff;
  logic         seq_known_ff;
  logic         seq_ok;
  logic         accept;

  assign seq_ok = !seq_known_ff || (rx_frame.seq == exp_seq_ff);
  // Reserved bits are not looked at.
  assign accept = frame_rdy_ff && p_st_ff == IFS_P_IDLE && crc_ok
                  && seq_ok;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      exp_seq_ff   <= 2'h0;
      seq_known_ff <= 1'b0;
    end else if (accept) begin
      exp_seq_ff   <= rx_frame.seq + 2'h1;
      seq_known_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      p_st_ff          <= IFS_P_IDLE;
      resp_ff          <= '0;
      pend_ff          <= 1'b0;
      pend_baud_ff     <= `IFS_BAUD_DEF;
      syscfg_stb_out   <= 1'b0;
      syscfg_out       <= '0;
      param_rd_stb_out <= 1'b0;
      param_wr_stb_out <= 1'b0;
      param_out        <= '0;
    end else begin
      syscfg_stb_out   <= 1'b0;
      param_rd_stb_out <= 1'b0;
      param_wr_stb_out <= 1'b0;
      unique case (p_st_ff)
        IFS_P_IDLE: begin
          if (accept) begin
            p_st_ff      <= IFS_P_SEND;
            resp_ff      <= rx_frame;
            resp_ff.res  <= `IFS_RES_VAL;
            unique case (rx_frame.mo)
              `IFS_MO_INQ: begin
                if (rx_frame.data[0] == `IFS_INQ_STATE) begin
                  resp_ff.data <= {`IFS_FILL, `IFS_FILL,
                                   pfc_state_in, motor_state_in};
                end else if (rx_frame.data[0] == `IFS_INQ_LOAD) begin
                  resp_ff.data <= {cpu_load_in,
                                   exec_time_in};
                end
              end
              `IFS_MO_SYSCFG: begin
                syscfg_stb_out <= 1'b1;
                syscfg_out     <= {rx_frame.data[1], rx_frame.data[0],
                                   rx_frame.data[3], rx_frame.data[2]};
                if ({rx_frame.data[1], rx_frame.data[0]} == `IFS_CMD_BAUD
                    && {rx_frame.data[3], rx_frame.data[2]}
                       >= `IFS_BAUD_MIN
                    && {rx_frame.data[3], rx_frame.data[2]}
                       <= `IFS_BAUD_MAX) begin
                  pend_ff      <= 1'b1;
                  pend_baud_ff <= {rx_frame.data[3], rx_frame.data[2]};
                end
              end
              `IFS_MO_PRD: begin
                param_rd_stb_out <= 1'b1;
                param_out        <= {rx_frame.data[0], rx_frame.data[1],
                                     16'h0000};
                p_st_ff          <= IFS_P_PWAIT;
              end
              `IFS_MO_PWR: begin
                param_wr_stb_out <= 1'b1;
                param_out        <= {rx_frame.data[0], rx_frame.data[1],
                                     rx_frame.data[3], rx_frame.data[2]};
              end
              default: begin
              end
            endcase
          end
        end
        IFS_P_PWAIT: begin
          resp_ff.data[3] <= param_rdata_in[15:8];
          resp_ff.data[2] <= param_rdata_in[7:0];
          p_st_ff         <= IFS_P_SEND;
        end
        IFS_P_SEND: begin
          if (tx_done) begin
            p_st_ff <= IFS_P_IDLE;
            pend_ff <= 1'b0;
          end
        end
        default: begin
          p_st_ff <= IFS_P_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reply transmitter
  // ----------------------------------------------------------------
  logic [2:0] tx_byte_ff;
  logic [3:0] tx_bit_ff;
  logic [1:0] tx_ph_ff;
  logic       tx_ff;
  logic [7:0] cur_byte;
  logic       nxt_tx;

  assign cur_byte = reply_byte(tx_byte_ff, resp_ff,
                               frame_crc(resp_ff.mo, resp_ff.data));
  assign tx_done  = p_st_ff == IFS_P_SEND && tick && tx_ph_ff == 2'h3
                    && tx_bit_ff == 4'h9 && tx_byte_ff == 3'h7;

  always_comb begin
    nxt_tx = 1'b1;
    if (tx_bit_ff == 4'h0) begin
      nxt_tx = 1'b0;
    end else if (tx_bit_ff <= 4'h8) begin
      nxt_tx = cur_byte[3'(tx_bit_ff - 4'h1)];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_byte_ff <= 3'h0;
      tx_bit_ff  <= 4'h0;
      tx_ph_ff   <= 2'h0;
      tx_ff      <= 1'b1;
    end else if (p_st_ff != IFS_P_SEND || !link_en) begin
      tx_byte_ff <= 3'h0;
      tx_bit_ff  <= 4'h0;
      tx_ph_ff   <= 2'h0;
      tx_ff      <= 1'b1;
    end else begin
      tx_ff <= nxt_tx;
      if (tick) begin
        tx_ph_ff <= tx_ph_ff + 2'h1;
        if (tx_ph_ff == 2'h3) begin
          if (tx_bit_ff == 4'h9) begin
            tx_bit_ff  <= 4'h0;
            tx_byte_ff <= tx_byte_ff + 3'h1;
          end else begin
            tx_bit_ff <= tx_bit_ff + 4'h1;
          end
        end
      end
    end
  end

  assign tx_out         = tx_ff;
  assign baud_value_out = baud_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_tx_idle_high: assert property ($past(p_st_ff) != IFS_P_SEND
    |-> tx_out)
    else $error("tx line active without a reply in progress");
  chk_crc_drop: assert property (frame_rdy_ff && !crc_ok
    && p_st_ff == IFS_P_IDLE |=> p_st_ff == IFS_P_IDLE [*2])
    else $error("frame with bad crc was answered");
  chk_seq_drop: assert property (frame_rdy_ff && seq_known_ff
    && rx_frame.seq != exp_seq_ff && p_st_ff == IFS_P_IDLE
    |=> p_st_ff == IFS_P_IDLE)
    else $error("frame with wrong sequence was answered");
  chk_seq_advance: assert property (accept
    |=> exp_seq_ff == 2'($past(rx_frame.seq) + 2'h1)
    && resp_ff.seq == $past(rx_frame.seq))
    else $error("sequence not advanced or not echoed");
  chk_res_zero: assert property (p_st_ff == IFS_P_SEND
    |-> resp_ff.res == `IFS_RES_VAL)
    else $error("reserved bits of reply not zero");
  chk_err_fallback: assert property (ferr_stb
    && err_cnt_ff == `IFS_ERR_LIMIT
    |=> baud_ff == `IFS_BAUD_DEF && err_cnt_ff == 3'h0)
    else $error("rate not restored after framing errors");
  chk_link_off: assert property (!link_en
    |=> rx_st_ff == IFS_R_IDLE && fr_cnt_ff == 4'h0 && !byte_stb_ff)
    else $error("receiver active while link disabled");
  chk_inq_state: assert property (accept
    && rx_frame.mo == `IFS_MO_INQ && rx_frame.data[0] == `IFS_INQ_STATE
    |=> resp_ff.data[3] == `IFS_FILL && resp_ff.data[2] == `IFS_FILL
    && resp_ff.data[1] == $past(pfc_state_in)
    && resp_ff.data[0] == $past(motor_state_in))
    else $error("state inquiry reply malformed");
  chk_one_reply: assert property (accept |=> p_st_ff != IFS_P_IDLE)
    else $error("good command not answered");

endmodule : ifs_frame_slave

// [inc/ifs_cfg.svh]
// Constants of the inter-chip serial link frame slave.
`ifndef IFS_CFG_SVH
`define IFS_CFG_SVH

`define IFS_FLAG       8'h7e
`define IFS_RES_VAL    2'h0
`define IFS_FILL       8'hff
`define IFS_MO_INQ     4'h0
`define IFS_MO_SYSCFG  4'h1
`define IFS_MO_PRD     4'h6
`define IFS_MO_PWR     4'h7
`define IFS_INQ_STATE  8'h00
`define IFS_INQ_LOAD   8'h01
`define IFS_CMD_BAUD   16'h0100
// Bit rate values are in units of 100 bit/s.
`define IFS_BAUD_DEF   16'h2710
`define IFS_BAUD_MIN   16'h003d
`define IFS_BAUD_MAX   16'hea60
`define IFS_CLK_HZ     27'h2625a00
`define IFS_RATE_MUL   26'h0000190
`define IFS_ERR_LIMIT  3'h3
`define IFS_CRC_POLY   8'h07
`define IFS_CRC_INIT   8'h00

`endif

// [inc/ifs_pkg.sv]
// Types of the inter-chip serial link frame slave.
package ifs_pkg;

  typedef struct packed {
    logic [1:0]      seq;
    logic [1:0]      res;
    logic [3:0]      mo;
    logic [3:0][7:0] data;
  } ifs_frame_t;

  typedef struct packed {
    logic [7:0]  app;
    logic [7:0]  idx;
    logic [15:0] val;
  } ifs_param_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] val;
  } ifs_syscfg_t;

  typedef enum logic [1:0] {
    IFS_R_IDLE,
    IFS_R_START,
    IFS_R_DATA,
    IFS_R_STOP
  } ifs_rx_st_t;

  typedef enum logic [1:0] {
    IFS_P_IDLE,
    IFS_P_PWAIT,
    IFS_P_SEND
  } ifs_proc_st_t;

endpackage : ifs_pkg

// [tb/ifs_master_model.sv]
// Behavioural link master: sends command bytes and collects reply bytes.
`include "ifs_cfg.svh"

module ifs_master_model (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned bit_clks = 40;
  int unsigned starts   = 0;
  logic [7:0]  rx_q[$];

  initial line_out = 1'b1;

  function automatic logic [7:0] crc8(input logic [3:0]      mo,
                                      input logic [3:0][7:0] d);
    logic [7:0]  c;
    logic [39:0] s;
    c = `IFS_CRC_INIT;
    s = {4'h0, mo, d[0], d[1], d[2], d[3]};
    for (int i = 39; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ s[i]) ? `IFS_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // A zero stop bit is followed by one idle bit so the line ends high.
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] sh;
    sh = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= sh[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    if (!stop) begin
      line_out <= 1'b1;
      repeat (bit_clks) @(posedge clk_in);
    end
  endtask : send_byte

  task automatic send_frame(input logic [1:0]      seq,
                            input logic [1:0]      res,
                            input logic [3:0]      mo,
                            input logic [3:0][7:0] d,
                            input logic [7:0]      bad);
    send_byte(`IFS_FLAG, 1'b1);
    send_byte({seq, res, mo}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      send_byte(d[i], 1'b1);
    end
    send_byte(crc8(mo, d) ^ bad, 1'b1);
    send_byte(`IFS_FLAG, 1'b1);
  endtask : send_frame

  // Samples each reply bit in its middle.
  always begin : collect
    logic [7:0] b;
    @(negedge line_in);
    starts++;
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk_in);
      b[i] = line_in;
    end
    repeat (bit_clks) @(posedge clk_in);
    rx_q.push_back(b);
  end
endmodule : ifs_master_model

// [tb/tb_intercore_frame_slave.sv]
// Self-checking bench of the inter-chip serial link frame slave.
`include "ifs_cfg.svh"

module tb_intercore_frame_slave
  import ifs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in, reset_n_in, rx_in, tx_out;
  logic [2:0]  link_cfg_in;
  logic [7:0]  motor_state_in, pfc_state_in;
  logic [15:0] exec_time_in, cpu_load_in, param_rdata_in, baud_value_out;
  logic        syscfg_stb_out, param_rd_stb_out, param_wr_stb_out;
  ifs_syscfg_t syscfg_out;
  ifs_param_t  param_out;
  int          errors = 0, check_count = 0;
  int          n_cfg = 0, n_rd = 0, n_wr = 0;
  logic [1:0]  sq;

  ifs_frame_slave dut (
    .clk_in, .reset_n_in, .link_cfg_in, .rx_in, .motor_state_in,
    .pfc_state_in, .exec_time_in, .cpu_load_in, .param_rdata_in, .tx_out,
    .baud_value_out, .syscfg_stb_out, .syscfg_out, .param_rd_stb_out,
    .param_wr_stb_out, .param_out
  );

  ifs_master_model m (.clk_in(clk_in), .line_in(tx_out), .line_out(rx_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(negedge clk_in) begin
    if (syscfg_stb_out === 1'b1) n_cfg++;
    if (param_rd_stb_out === 1'b1) n_rd++;
    if (param_wr_stb_out === 1'b1) n_wr++;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic rand_inputs();
    link_cfg_in    <= 3'($urandom_range(1, 7));
    motor_state_in <= 8'($urandom());
    pfc_state_in   <= 8'($urandom());
    exec_time_in   <= 16'($urandom());
    cpu_load_in    <= 16'($urandom());
    param_rdata_in <= 16'($urandom());
    @(posedge clk_in);
  endtask : rand_inputs

  function automatic logic [3:0][7:0] exp_data(input logic [3:0]      mo,
                                               input logic [3:0][7:0] d);
    if (mo == `IFS_MO_INQ && d[0] == `IFS_INQ_STATE) begin
      return {`IFS_FILL, `IFS_FILL, pfc_state_in, motor_state_in};
    end
    if (mo == `IFS_MO_INQ && d[0] == `IFS_INQ_LOAD) begin
      return {cpu_load_in, exec_time_in};
    end
    if (mo == `IFS_MO_PRD) begin
      return {param_rdata_in, d[1], d[0]};
    end
    return d;
  endfunction : exp_data

  task automatic xfer(input logic [3:0] mo, input logic [3:0][7:0] d,
                      input logic [1:0] s, input logic [7:0] bad,
                      input bit reply);
    logic [7:0]      exp_q[8];
    logic [3:0][7:0] e;
    int              c0, r0, w0, s0;
    repeat (2 * m.bit_clks) @(posedge clk_in);
    c0 = n_cfg;
    r0 = n_rd;
    w0 = n_wr;
    s0 = m.starts;
    m.rx_q.delete();
    e = exp_data(mo, d);
    exp_q = '{`IFS_FLAG, {s, 2'b00, mo}, e[0], e[1], e[2], e[3],
              m.crc8(mo, e), `IFS_FLAG};
    // Reserved value 3 is left out so that no header can look like a flag.
    m.send_frame(s, 2'($urandom_range(0, 2)), mo, d, bad);
    if (reply) begin
      for (int i = 0; i < 100 * m.bit_clks && m.rx_q.size() < 8; i++) begin
        @(posedge clk_in);
      end
      check(32'(m.rx_q.size()), 32'd8, "reply length");
      for (int i = 0; i < m.rx_q.size(); i++) begin
        check(m.rx_q[i], exp_q[i], "reply byte");
      end
    end else begin
      repeat (20 * m.bit_clks) @(posedge clk_in);
      check(32'(m.starts - s0), 32'd0, "reply seen");
    end
    check(32'(n_cfg - c0), 32'(reply && mo == `IFS_MO_SYSCFG), "cfg");
    check(32'(n_rd - r0), 32'(reply && mo == `IFS_MO_PRD), "rd");
    check(32'(n_wr - w0), 32'(reply && mo == `IFS_MO_PWR), "wr");
    if (reply && mo == `IFS_MO_SYSCFG) begin
      check(syscfg_out, {d[1], d[0], d[3], d[2]}, "syscfg");
    end
    if (reply && mo == `IFS_MO_PRD) begin
      check(param_out, {d[0], d[1], 16'h0000}, "param rd");
    end
    if (reply && mo == `IFS_MO_PWR) begin
      check(param_out, {d[0], d[1], d[3], d[2]}, "param wr");
    end
  endtask : xfer

  task automatic good(input logic [3:0] mo, input logic [3:0][7:0] d);
    xfer(mo, d, sq, 8'h00, 1'b1);
    sq = sq + 2'd1;
  endtask : good

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin : main
    logic [3:0]      mo;
    logic [3:0][7:0] d;
    void'($urandom(32'h6bb9));
    reset_n_in     = 1'b0;
    link_cfg_in    = 3'h0;
    motor_state_in = 8'h00;
    pfc_state_in   = 8'h00;
    exec_time_in   = 16'h0000;
    cpu_load_in    = 16'h0000;
    param_rdata_in = 16'h0000;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    check(32'(tx_out), 32'd1, "idle line");
    check(32'(baud_value_out), 32'h2710, "reset rate");
    xfer(4'h0, 32'h0, 2'd1, 8'h00, 1'b0);
    rand_inputs();
    sq = 2'd3;
    good(4'h0, {24'($urandom()), `IFS_INQ_STATE});
    good(4'h0, {24'($urandom()), `IFS_INQ_LOAD});
    xfer(4'h1, 32'($urandom()), sq + 2'd1, 8'h00, 1'b0);
    xfer(4'h1, 32'($urandom()), sq, 8'h40, 1'b0);
    good(4'h1, 32'h003c0100);
    good(4'h1, 32'h4e200100);
    check(32'(baud_value_out), 32'h2710, "rate mid reply");
    repeat (m.bit_clks) @(posedge clk_in);
    check(32'(baud_value_out), 32'h4e20, "new rate");
    m.bit_clks = 20;
    good(4'h6, 32'($urandom()));
    good(4'h7, 32'($urandom()));
    repeat (6) begin
      rand_inputs();
      mo = 4'($urandom());
      d  = 32'($urandom());
      if (mo == `IFS_MO_INQ) d[0] = 8'($urandom_range(0, 2));
      good(mo, d);
    end
    for (int k = 1; k <= 4; k++) begin
      m.send_byte(8'h00, 1'b0);
      repeat (4 * m.bit_clks) @(posedge clk_in);
      check(32'(baud_value_out), (k < 4) ? 32'h4e20 : 32'h2710, "fall");
    end
    m.bit_clks = 40;
    good(4'h2, 32'($urandom()));
    report_and_stop();
  end

  initial begin : watchdog
    repeat (100000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end
endmodule : tb_intercore_frame_slave
